// ===== verification/st2_timer_tb.sv
// self-checking testbench for the split auto-reload timer with capture
`timescale 1ns/1ps
`default_nettype none
module st2_timer_tb;
  import st2_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic ext_osc = 1'b0;
  logic ext_ph = 1'b0;
  st2_addr_t addr = 4'h0;
  st2_byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  st2_timer i_dut (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .ext_osc(ext_osc),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .irq(irq)
  );

  always #50 mclk = ~mclk;

  // oscillator of four system clocks, so one divided period is exactly 32 clocks
  always @(posedge mclk) begin
    ext_ph <= ~ext_ph;
    if (ext_ph) begin
      ext_osc <= ~ext_osc;
    end
  end

  // whole run needs about 1000 clocks
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      $display("Error at %0t: run did not finish", $time);
      results();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // tick phase of the divided clocks is free, so some counts carry a tolerance
  task automatic check_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    check({15'h0000, (got >= lo) && (got <= hi)}, 16'h0001);
  endtask

  task automatic wr_reg(input st2_addr_t a, input st2_byte_t d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input st2_addr_t a, output st2_byte_t d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input st2_addr_t a, input st2_byte_t exp);
    st2_byte_t d;
    rd_reg(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  task automatic rd_rng(input st2_addr_t a, input st2_byte_t lo, input st2_byte_t hi);
    st2_byte_t d;
    rd_reg(a, d);
    check_rng(d, lo, hi);
  endtask

  // irq is registered one clock behind the flags
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge mclk);
    #1;
    check({15'h0000, irq}, {15'h0000, exp});
  endtask

  task automatic t_reset();
    for (int i = 0; i < 16; i++) rd_chk(4'(i), RST_BYTE);
    wr_reg(4'h9, 8'hff);
    rd_chk(4'h9, 8'h00);
    wr_reg(ADDR_RELOAD_LOW, 8'ha5);
    wr_reg(ADDR_RELOAD_HIGH, 8'h5a);
    wr_reg(ADDR_COUNT_LOW, 8'h3c);
    wr_reg(ADDR_COUNT_HIGH, 8'hc3);
    rd_chk(ADDR_RELOAD_LOW, 8'ha5);
    rd_chk(ADDR_RELOAD_HIGH, 8'h5a);
    rd_chk(ADDR_COUNT_LOW, 8'h3c);
    rd_chk(ADDR_COUNT_HIGH, 8'hc3);
    wr_reg(ADDR_TIMER_CTL, 8'h02);
    rd_chk(ADDR_TIMER_CTL, 8'h00);
    $display("reset and access test done");
  endtask

  task automatic t_wrap16();
    st2_byte_t a;
    st2_byte_t b;
    wr_reg(ADDR_CLOCK_CTL, 8'h10);
    wr_reg(ADDR_RELOAD_LOW, 8'h34);
    wr_reg(ADDR_RELOAD_HIGH, 8'h12);
    wr_reg(ADDR_COUNT_LOW, 8'hfd);
    wr_reg(ADDR_COUNT_HIGH, 8'hff);
    wr_reg(ADDR_IRQ_ENABLE, 8'h20);
    wr_reg(ADDR_TIMER_CTL, 8'h04);
    repeat (6) @(posedge mclk);
    rd_chk(ADDR_TIMER_CTL, 8'hc4);
    chk_irq(1'b1);
    repeat (20) @(posedge mclk);
    rd_chk(ADDR_TIMER_CTL, 8'hc4);
    wr_reg(ADDR_TIMER_CTL, 8'h00);
    rd_chk(ADDR_COUNT_HIGH, 8'h12);
    rd_rng(ADDR_COUNT_LOW, 8'h34, 8'h60);
    rd_reg(ADDR_COUNT_LOW, a);
    rd_reg(ADDR_COUNT_LOW, b);
    check({8'h00, b}, {8'h00, a});
    chk_irq(1'b0);
    $display("16-bit wrap test done");
  endtask

  task automatic t_low16();
    wr_reg(ADDR_COUNT_LOW, 8'hfe);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_TIMER_CTL, 8'h24);
    repeat (6) @(posedge mclk);
    rd_chk(ADDR_TIMER_CTL, 8'h64);
    chk_irq(1'b1);
    wr_reg(ADDR_TIMER_CTL, 8'h40);
    chk_irq(1'b0);
    rd_chk(ADDR_COUNT_HIGH, 8'h01);
    wr_reg(ADDR_TIMER_CTL, 8'h00);
    $display("low byte interrupt test done");
  endtask

  task automatic t_split();
    wr_reg(ADDR_RELOAD_LOW, 8'ha0);
    wr_reg(ADDR_RELOAD_HIGH, 8'h77);
    wr_reg(ADDR_COUNT_LOW, 8'hfe);
    wr_reg(ADDR_COUNT_HIGH, 8'h50);
    wr_reg(ADDR_TIMER_CTL, 8'h08);
    repeat (6) @(posedge mclk);
    rd_chk(ADDR_TIMER_CTL, 8'h48);
    chk_irq(1'b0);
    rd_chk(ADDR_COUNT_HIGH, 8'h50);
    rd_rng(ADDR_COUNT_LOW, 8'ha0, 8'hb8);
    wr_reg(ADDR_TIMER_CTL, 8'h68);
    chk_irq(1'b1);
    wr_reg(ADDR_CLOCK_CTL, 8'h30);
    wr_reg(ADDR_COUNT_HIGH, 8'hfe);
    wr_reg(ADDR_TIMER_CTL, 8'h0c);
    repeat (6) @(posedge mclk);
    rd_chk(ADDR_TIMER_CTL, 8'h8c);
    chk_irq(1'b1);
    rd_rng(ADDR_COUNT_HIGH, 8'h77, 8'h8f);
    wr_reg(ADDR_TIMER_CTL, 8'h00);
    wr_reg(ADDR_IRQ_ENABLE, 8'h00);
    $display("split mode test done");
  endtask

  task automatic t_clk();
    wr_reg(ADDR_CLOCK_CTL, 8'h00);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_TIMER_CTL, 8'h04);
    repeat (120) @(posedge mclk);
    wr_reg(ADDR_TIMER_CTL, 8'h00);
    rd_rng(ADDR_COUNT_LOW, 8'h09, 8'h0b);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_TIMER_CTL, 8'h05);
    repeat (320) @(posedge mclk);
    wr_reg(ADDR_TIMER_CTL, 8'h01);
    rd_rng(ADDR_COUNT_LOW, 8'h09, 8'h0b);
    $display("clock select test done");
  endtask

  // clearing the flag before reading the pair keeps each read inside one capture period
  task automatic wait_cap(output logic [15:0] cap);
    st2_byte_t d;
    st2_byte_t lo;
    d = 8'h00;
    for (int n = 0; n < 40 && d[7] !== 1'b1; n++) rd_reg(ADDR_TIMER_CTL, d);
    check({15'h0000, d[7]}, 16'h0001);
    wr_reg(ADDR_TIMER_CTL, 8'h14);
    rd_reg(ADDR_RELOAD_LOW, lo);
    rd_reg(ADDR_RELOAD_HIGH, d);
    cap = {d, lo};
  endtask

  task automatic t_capture();
    logic [15:0] c1;
    logic [15:0] c2;
    wr_reg(ADDR_CLOCK_CTL, 8'h10);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_TIMER_CTL, 8'h14);
    wait_cap(c1);
    wait_cap(c2);
    check(c2 - c1, 16'h0020);
    wr_reg(ADDR_TIMER_CTL, 8'h00);
    $display("capture test done");
  endtask

  // enable low freezes the count; a reset in mid-run clears everything again
  task automatic t_ce_rst();
    wr_reg(ADDR_CLOCK_CTL, 8'h10);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_TIMER_CTL, 8'h04);
    ce <= 1'b0;
    repeat (50) @(posedge mclk);
    ce <= 1'b1;
    wr_reg(ADDR_TIMER_CTL, 8'h00);
    rd_chk(ADDR_COUNT_LOW, 8'h02);
    wr_reg(ADDR_RELOAD_LOW, 8'h5a);
    wr_reg(ADDR_TIMER_CTL, 8'h04);
    repeat (5) @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(ADDR_COUNT_LOW, RST_BYTE);
    rd_chk(ADDR_RELOAD_LOW, RST_BYTE);
    rd_chk(ADDR_TIMER_CTL, RST_BYTE);
    $display("clock enable and reset test done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_wrap16();
    t_low16();
    t_split();
    t_clk();
    t_capture();
    t_ce_rst();
    results();
  end
endmodule // st2_timer_tb
`default_nettype wire

// ===== verilog/st2_pkg.sv
// constants shared by the split auto-reload timer with capture
package st2_pkg;
  localparam int unsigned ST2_AW = 4;
  localparam int unsigned ST2_DW = 8;
  typedef logic [ST2_AW-1:0] st2_addr_t;
  typedef logic [ST2_DW-1:0] st2_byte_t;
  // register offsets
  localparam st2_addr_t ADDR_TIMER_CTL = 4'h0;
  localparam st2_addr_t ADDR_CLOCK_CTL = 4'h1;
  localparam st2_addr_t ADDR_RELOAD_LOW = 4'h2;
  localparam st2_addr_t ADDR_RELOAD_HIGH = 4'h3;
  localparam st2_addr_t ADDR_COUNT_LOW = 4'h4;
  localparam st2_addr_t ADDR_COUNT_HIGH = 4'h5;
  localparam st2_addr_t ADDR_IRQ_ENABLE = 4'h6;
  // timer_control_register fields
  localparam int unsigned BIT_HIGH_FLAG = 7;
  localparam int unsigned BIT_LOW_FLAG = 6;
  localparam int unsigned BIT_LOW_IRQ_EN = 5;
  localparam int unsigned BIT_CAPTURE_EN = 4;
  localparam int unsigned BIT_SPLIT = 3;
  localparam int unsigned BIT_RUN = 2;
  localparam int unsigned BIT_EXT_SEL = 0;
  // clock_control_register fields
  localparam int unsigned BIT_LOW_SYSCLK = 4;
  localparam int unsigned BIT_HIGH_SYSCLK = 5;
  // interrupt_enable_register field
  localparam int unsigned BIT_TIMER_IRQ_EN = 5;
  // reset values and the all-ones byte
  localparam st2_byte_t RST_BYTE = 8'h00;
  localparam logic RST_BIT = 1'b0;
  localparam st2_byte_t BYTE_MAX = 8'hff;
  // prescale counts
  localparam int unsigned SYS_DIV = 12;
  localparam int unsigned EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_RISE = 3'(EXT_DIV / 2 - 1);
  localparam logic [2:0] EXT_DIV_FALL = 3'(EXT_DIV - 1);
endpackage

// ===== verilog/st2_prescale.sv
// sysclk/12 tick and synchronised external oscillator /8 ticks
`timescale 1ns/1ps
`default_nettype none
module st2_prescale (
  // clock and control
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // external oscillator
  input wire logic ext_osc,
  // ticks
  st2_tick_if.src tk
);
  import st2_pkg::*;

  logic [3:0] div12_reg, div12_next;
  logic [2:0] div8_reg, div8_next;
  logic sync1_reg, sync2_reg, sync3_reg;
  logic t12_reg, t12_next, t8_reg, t8_next, f8_reg, f8_next;
  logic ext_rise;

  always_comb begin
    ext_rise = sync2_reg & ~sync3_reg;
    div12_next = (div12_reg == SYS_DIV_LAST) ? 4'h0 : div12_reg + 4'h1;
    t12_next = (div12_reg == SYS_DIV_LAST);
    div8_next = ext_rise ? div8_reg + 3'h1 : div8_reg;
    // divided clock is high for counts 4..7, so it falls on the 7 to 0 step
    t8_next = ext_rise && (div8_reg == EXT_DIV_RISE);
    f8_next = ext_rise && (div8_reg == EXT_DIV_FALL);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      div12_reg <= 4'h0;
      div8_reg <= 3'h0;
      sync1_reg <= RST_BIT;
      sync2_reg <= RST_BIT;
      sync3_reg <= RST_BIT;
      t12_reg <= RST_BIT;
      t8_reg <= RST_BIT;
      f8_reg <= RST_BIT;
    end else if (ce) begin
      div12_reg <= div12_next;
      div8_reg <= div8_next;
      sync1_reg <= ext_osc;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      t12_reg <= t12_next;
      t8_reg <= t8_next;
      f8_reg <= f8_next;
    end
  end

  assign tk.div12_tick = t12_reg;
  assign tk.ext8_tick = t8_reg;
  assign tk.ext8_fall = f8_reg;
endmodule // st2_prescale
`default_nettype wire

// ===== verilog/st2_tick_if.sv
// tick strobes from the prescaler to the timer core
`timescale 1ns/1ps
`default_nettype none
interface st2_tick_if;
  logic div12_tick;
  logic ext8_tick;
  logic ext8_fall;
  modport src (output div12_tick, output ext8_tick, output ext8_fall);
  modport dst (input div12_tick, input ext8_tick, input ext8_fall);
endinterface // st2_tick_if
`default_nettype wire

// ===== verilog/st2_timer.sv
// split auto-reload timer with external oscillator capture
// Behaviour
// - count is 16 bits: low and high byte registers, software read and write
// - split bit 3 of control: 0 one 16-bit reload timer, 1 two 8-bit
// - tick from sysclk, sysclk/12 or synchronised external oscillator /8
// - 16-bit wrap from ffff loads the reload pair and sets high flag
// - timer irq enable requests interrupt on each 16-bit overflow
// - 16-bit mode with low irq enable: low byte wrap also interrupts
// - split mode: each half reloads from its own reload byte
// - split mode: run gates high half only; low half always counts
// - per-half sysclk select; else external select picks /12 or ext/8
// - split mode: each half's wrap sets its own overflow flag
// - split: high wrap interrupts; with low irq enable either half does
// - hardware never clears flags; software clears and reads both
// - capture mode detects each falling edge of external clock /8
// - capture copies full count to reload pair and sets high flag
// - capture mode counts sysclk or sysclk/12 by low-half select
// - capture enable bit turns capture on; sysclk select counts every clock
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module st2_timer (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // external oscillator
  input wire logic ext_osc,
  // register port
  input wire st2_pkg::st2_addr_t addr,
  input wire st2_pkg::st2_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // interrupt request
  output logic irq
);
  import st2_pkg::*;

  st2_tick_if tk ();

  st2_prescale u_pre (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .ext_osc(ext_osc),
    .tk(tk)
  );

  logic high_overflow_flag_reg, high_overflow_flag_next;
  logic low_overflow_flag_reg, low_overflow_flag_next;
  logic low_flag_irq_enable_reg, low_flag_irq_enable_next;
  logic capture_enable_reg, capture_enable_next;
  logic split_mode_select_reg, split_mode_select_next;
  logic run_control_reg, run_control_next;
  logic external_clock_select_reg, external_clock_select_next;
  logic low_half_sysclk_select_reg, low_half_sysclk_select_next;
  logic high_half_sysclk_select_reg, high_half_sysclk_select_next;
  logic timer_irq_enable_reg, timer_irq_enable_next;
  st2_byte_t reload_low_byte_reg, reload_low_byte_next;
  st2_byte_t reload_high_byte_reg, reload_high_byte_next;
  st2_byte_t count_low_byte_reg, count_low_byte_next;
  st2_byte_t count_high_byte_reg, count_high_byte_next;
  st2_byte_t rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic tick_low, tick_high, count_wr, set_high, set_low;
  logic [15:0] count16;

  function automatic logic sel_tick(input logic sys_sel, input logic ext_sel,
                                    input logic t12, input logic t8);
    sel_tick = sys_sel ? 1'b1 : (ext_sel ? t8 : t12);
  endfunction

  always_comb begin
    high_overflow_flag_next = high_overflow_flag_reg;
    low_overflow_flag_next = low_overflow_flag_reg;
    low_flag_irq_enable_next = low_flag_irq_enable_reg;
    capture_enable_next = capture_enable_reg;
    split_mode_select_next = split_mode_select_reg;
    run_control_next = run_control_reg;
    external_clock_select_next = external_clock_select_reg;
    low_half_sysclk_select_next = low_half_sysclk_select_reg;
    high_half_sysclk_select_next = high_half_sysclk_select_reg;
    timer_irq_enable_next = timer_irq_enable_reg;
    reload_low_byte_next = reload_low_byte_reg;
    reload_high_byte_next = reload_high_byte_reg;
    count_low_byte_next = count_low_byte_reg;
    count_high_byte_next = count_high_byte_reg;
    set_high = 1'b0;
    set_low = 1'b0;
    count16 = {count_high_byte_reg, count_low_byte_reg};
    // capture measures the oscillator, so it cannot also clock the low half or the 16-bit count
    tick_low = sel_tick(low_half_sysclk_select_reg,
                        external_clock_select_reg & ~capture_enable_reg,
                        tk.div12_tick, tk.ext8_tick);
    tick_high = sel_tick(high_half_sysclk_select_reg, external_clock_select_reg,
                         tk.div12_tick, tk.ext8_tick);
    // a software write to either count byte takes that cycle over
    count_wr = wr && (addr == ADDR_COUNT_LOW || addr == ADDR_COUNT_HIGH);
    if (!split_mode_select_reg) begin
      if (run_control_reg && tick_low && !count_wr) begin
        if (count16 == {BYTE_MAX, BYTE_MAX}) begin
          {count_high_byte_next, count_low_byte_next} =
            {reload_high_byte_reg, reload_low_byte_reg};
          set_high = 1'b1;
        end else begin
          {count_high_byte_next, count_low_byte_next} = count16 + 16'h0001;
        end
        if (count_low_byte_reg == BYTE_MAX) begin
          set_low = 1'b1;
        end
      end
    end else begin
      if (tick_low && !count_wr) begin
        if (count_low_byte_reg == BYTE_MAX) begin
          count_low_byte_next = reload_low_byte_reg;
          set_low = 1'b1;
        end else begin
          count_low_byte_next = count_low_byte_reg + 8'h01;
        end
      end
      if (run_control_reg && tick_high && !count_wr) begin
        if (count_high_byte_reg == BYTE_MAX) begin
          count_high_byte_next = reload_high_byte_reg;
          set_high = 1'b1;
        end else begin
          count_high_byte_next = count_high_byte_reg + 8'h01;
        end
      end
    end
    if (wr) begin
      unique case (addr)
        ADDR_TIMER_CTL: begin
          high_overflow_flag_next = wdata[BIT_HIGH_FLAG];
          low_overflow_flag_next = wdata[BIT_LOW_FLAG];
          low_flag_irq_enable_next = wdata[BIT_LOW_IRQ_EN];
          capture_enable_next = wdata[BIT_CAPTURE_EN];
          split_mode_select_next = wdata[BIT_SPLIT];
          run_control_next = wdata[BIT_RUN];
          external_clock_select_next = wdata[BIT_EXT_SEL];
        end
        ADDR_CLOCK_CTL: begin
          low_half_sysclk_select_next = wdata[BIT_LOW_SYSCLK];
          high_half_sysclk_select_next = wdata[BIT_HIGH_SYSCLK];
        end
        ADDR_RELOAD_LOW: reload_low_byte_next = wdata;
        ADDR_RELOAD_HIGH: reload_high_byte_next = wdata;
        ADDR_COUNT_LOW: count_low_byte_next = wdata;
        ADDR_COUNT_HIGH: count_high_byte_next = wdata;
        ADDR_IRQ_ENABLE: timer_irq_enable_next = wdata[BIT_TIMER_IRQ_EN];
        default: ;
      endcase
    end
    // capture wins over a reload write in the same cycle
    if (capture_enable_reg && tk.ext8_fall) begin
      {reload_high_byte_next, reload_low_byte_next} = count16;
      set_high = 1'b1;
    end
    // a hardware set wins over a software clear
    high_overflow_flag_next = high_overflow_flag_next | set_high;
    low_overflow_flag_next = low_overflow_flag_next | set_low;
    rdata_next = RST_BYTE;
    if (rd) begin
      unique case (addr)
        ADDR_TIMER_CTL: rdata_next = {high_overflow_flag_reg, low_overflow_flag_reg,
                                      low_flag_irq_enable_reg, capture_enable_reg,
                                      split_mode_select_reg, run_control_reg, 1'b0,
                                      external_clock_select_reg};
        ADDR_CLOCK_CTL: rdata_next = {2'h0, high_half_sysclk_select_reg,
                                      low_half_sysclk_select_reg, 4'h0};
        ADDR_RELOAD_LOW: rdata_next = reload_low_byte_reg;
        ADDR_RELOAD_HIGH: rdata_next = reload_high_byte_reg;
        ADDR_COUNT_LOW: rdata_next = count_low_byte_reg;
        ADDR_COUNT_HIGH: rdata_next = count_high_byte_reg;
        ADDR_IRQ_ENABLE: rdata_next = {2'h0, timer_irq_enable_reg, 5'h0};
        default: rdata_next = RST_BYTE;
      endcase
    end
    // level request: stays up until software clears the flag
    irq_next = timer_irq_enable_reg & (high_overflow_flag_reg |
               (low_flag_irq_enable_reg & low_overflow_flag_reg));
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      high_overflow_flag_reg <= RST_BIT;
      low_overflow_flag_reg <= RST_BIT;
      low_flag_irq_enable_reg <= RST_BIT;
      capture_enable_reg <= RST_BIT;
      split_mode_select_reg <= RST_BIT;
      run_control_reg <= RST_BIT;
      external_clock_select_reg <= RST_BIT;
      low_half_sysclk_select_reg <= RST_BIT;
      high_half_sysclk_select_reg <= RST_BIT;
      timer_irq_enable_reg <= RST_BIT;
      reload_low_byte_reg <= RST_BYTE;
      reload_high_byte_reg <= RST_BYTE;
      count_low_byte_reg <= RST_BYTE;
      count_high_byte_reg <= RST_BYTE;
      rdata_reg <= RST_BYTE;
      irq_reg <= RST_BIT;
    end else if (ce) begin
      high_overflow_flag_reg <= high_overflow_flag_next;
      low_overflow_flag_reg <= low_overflow_flag_next;
      low_flag_irq_enable_reg <= low_flag_irq_enable_next;
      capture_enable_reg <= capture_enable_next;
      split_mode_select_reg <= split_mode_select_next;
      run_control_reg <= run_control_next;
      external_clock_select_reg <= external_clock_select_next;
      low_half_sysclk_select_reg <= low_half_sysclk_select_next;
      high_half_sysclk_select_reg <= high_half_sysclk_select_next;
      timer_irq_enable_reg <= timer_irq_enable_next;
      reload_low_byte_reg <= reload_low_byte_next;
      reload_high_byte_reg <= reload_high_byte_next;
      count_low_byte_reg <= count_low_byte_next;
      count_high_byte_reg <= count_high_byte_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;

  // checks
  property p_wrap16;
    @(posedge mclk) disable iff (srst)
    (ce && !split_mode_select_reg && run_control_reg && tick_low && !count_wr &&
     count16 == 16'hffff && !(capture_enable_reg && tk.ext8_fall))
    |=> ({count_high_byte_reg, count_low_byte_reg} ==
         $past({reload_high_byte_reg, reload_low_byte_reg})) && high_overflow_flag_reg;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload");

  property p_low_wrap16;
    @(posedge mclk) disable iff (srst)
    (ce && !split_mode_select_reg && run_control_reg && tick_low && !count_wr &&
     count_low_byte_reg == 8'hff) |=> low_overflow_flag_reg;
  endproperty
  a_low_wrap16: assert property (p_low_wrap16) else $error("low wrap flag lost");

  property p_split_low;
    @(posedge mclk) disable iff (srst)
    (ce && split_mode_select_reg && tick_low && !count_wr && count_low_byte_reg == 8'hff)
    |=> count_low_byte_reg == $past(reload_low_byte_reg) && low_overflow_flag_reg;
  endproperty
  a_split_low: assert property (p_split_low) else $error("low half reload wrong");

  property p_split_low_step;
    @(posedge mclk) disable iff (srst)
    (ce && split_mode_select_reg && tick_low && !count_wr && count_low_byte_reg != 8'hff)
    |=> count_low_byte_reg == 8'($past(count_low_byte_reg) + 8'h01);
  endproperty
  a_split_low_step: assert property (p_split_low_step) else $error("low half step");

  property p_high_hold;
    @(posedge mclk) disable iff (srst)
    (ce && split_mode_select_reg && !run_control_reg && !count_wr) |=> $stable(count_high_byte_reg);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high half ran while stopped");

  property p_high_sys;
    @(posedge mclk) disable iff (srst)
    (ce && split_mode_select_reg && run_control_reg && high_half_sysclk_select_reg &&
     !count_wr && count_high_byte_reg == 8'hff)
    |=> count_high_byte_reg == $past(reload_high_byte_reg) && high_overflow_flag_reg;
  endproperty
  a_high_sys: assert property (p_high_sys) else $error("high half sysclk wrap");

  property p_capture;
    @(posedge mclk) disable iff (srst)
    (ce && capture_enable_reg && tk.ext8_fall)
    |=> {reload_high_byte_reg, reload_low_byte_reg} == $past(count16) && high_overflow_flag_reg;
  endproperty
  a_capture: assert property (p_capture) else $error("capture not taken");

  property p_set_wins;
    @(posedge mclk) disable iff (srst)
    (ce && wr && addr == ADDR_TIMER_CTL && set_high) |=> high_overflow_flag_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag set lost to clear");

  property p_irq;
    @(posedge mclk) disable iff (srst)
    (ce && timer_irq_enable_reg && (high_overflow_flag_reg ||
     (low_flag_irq_enable_reg && low_overflow_flag_reg))) |=> irq_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not requested");

  property p_no_irq;
    @(posedge mclk) disable iff (srst)
    (ce && !high_overflow_flag_reg && !low_overflow_flag_reg) |=> !irq_reg;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("spurious interrupt");

  property p_rdata_idle;
    @(posedge mclk) disable iff (srst)
    (ce && !rd) |=> rdata_reg == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

  property p_hold16;
    @(posedge mclk) disable iff (srst)
    (ce && !split_mode_select_reg && !run_control_reg && !count_wr)
    |=> $stable({count_high_byte_reg, count_low_byte_reg});
  endproperty
  a_hold16: assert property (p_hold16) else $error("16-bit count ran while stopped");

  // only a control write may drop a flag
  property p_flag_kept;
    @(posedge mclk) disable iff (srst)
    (ce && !(wr && addr == ADDR_TIMER_CTL)) |=>
    (high_overflow_flag_reg || !$past(high_overflow_flag_reg)) &&
    (low_overflow_flag_reg || !$past(low_overflow_flag_reg));
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag cleared by hardware");

  property p_freeze;
    @(posedge mclk) disable iff (srst)
    !ce |=> $stable({count_high_byte_reg, count_low_byte_reg}) && $stable(rdata_reg) &&
    $stable(irq_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule // st2_timer
`default_nettype wire
